// >>> design/arcr_regs.vh
// Summary of operation
// - Voltage reference control bits 7:6 always read zero and ignore writes.
// - Voltage reference bit 5 picks chip ground (0) or analog ground pin (1).
// - Bits 4:3 pick the converter reference: pin, supply, 1.8 V, 1.65 V.
// - Bit 2 enables the temperature sensor when one, disables when zero.
// - Bit 1 is unused, reads zero and ignores writes.
// - Bit 0 enables the precision reference and ties it to the ref pin.
// - Current reference bit 7 selects source (0) or sink (1).
// - Bit 6 selects low-power range (0) or high-current x8 range (1).
// - Bits 5:0 give the step count; current is direction x step x count.
// - A zero step count holds the current reference in low-power off state.
// - Low range tops out at 63 unit steps; high range at 504 uA in 8 uA steps.
// - The high-speed reference is powered only while the converter needs it.
`ifndef ARCR_REGS_VH
`define ARCR_REGS_VH
`define ARCR_ADDR_CURRENT 8'hb9
`define ARCR_ADDR_VOLTAGE 8'hd1
`define ARCR_RESET_CURRENT 8'h00
`define ARCR_RESET_VOLTAGE 8'h18
`define ARCR_VOLTAGE_WMASK 8'h3d
`define ARCR_BIT_GND 5
`define ARCR_BIT_SRC_HI 4
`define ARCR_BIT_SRC_LO 3
`define ARCR_BIT_TEMP 2
`define ARCR_BIT_PREC 0
`define ARCR_BIT_SINK 7
`define ARCR_BIT_RANGE 6
`define ARCR_STEP_HI 5
`define ARCR_SRC_EXT_PIN 2'b00
`define ARCR_SRC_SUPPLY 2'b01
`define ARCR_SRC_DIG_1V8 2'b10
`define ARCR_SRC_HS_1V65 2'b11
`define ARCR_HIGH_STEP_MULT 4'h8
`endif

// >>> design/arcr_sync.v
`default_nettype none
module arcr_sync (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // async level in, stable level out
    input wire din,
    output reg dout
);
reg s1;
reg s2;
reg s3;
////////////////////////////////////////////////////////////////////////////
// three stages; change accepted once stage two and three agree
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        dout <= 1'b0;
    end else begin
        s1 <= din;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
            dout <= s3;
        end
    end
end
endmodule // arcr_sync
`default_nettype wire

// >>> design/arcr_current_ref.v
`include "arcr_regs.vh"
`default_nettype none
module arcr_current_ref (
    // stored register fields
    input wire [7:0] ctrl,
    // decoded analog controls
    output wire enable,
    output wire sink,
    output wire [8:0] magnitude
);
wire [5:0] count;
assign count = ctrl[`ARCR_STEP_HI:0];
assign enable = |count;
assign sink = ctrl[`ARCR_BIT_SINK];
// magnitude in 1 uA units, 63 or 504 max
assign magnitude = ctrl[`ARCR_BIT_RANGE]
    ? {count, 3'b000}
    : {3'b000, count};
endmodule // arcr_current_ref
`default_nettype wire

// >>> design/arcr_top.v
`include "arcr_regs.vh"
`default_nettype none
module arcr_top (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // special-function-register bus
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    // converter activity, from the converter's own clock domain
    input wire converter_busy,
    // voltage reference controls
    output reg analog_ground_select,
    output reg [1:0] vref_source_select,
    output reg temp_sensor_enable,
    output reg precision_ref_output_enable,
    output reg hs_ref_enable,
    // programmable current reference controls
    output reg iref_enable,
    output reg iref_sink,
    output reg [8:0] iref_magnitude_ua
);
////////////////////////////////////////////////////////////////////////////
// reset release through two flops
reg rst_q1;
reg rst_sync_b;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rst_q1 <= 1'b0;
        rst_sync_b <= 1'b0;
    end else begin
        rst_q1 <= 1'b1;
        rst_sync_b <= rst_q1;
    end
end

////////////////////////////////////////////////////////////////////////////
reg [7:0] voltage_reference_control;
reg [7:0] current_reference_control;
wire busy_sync;
wire cur_en;
wire cur_sink;
wire [8:0] cur_mag;

// converter request may come from another clock
arcr_sync u_busy_sync (
    .clk(clk),
    .rst_b(rst_sync_b),
    .din(converter_busy),
    .dout(busy_sync)
);

arcr_current_ref u_cur (
    .ctrl(current_reference_control),
    .enable(cur_en),
    .sink(cur_sink),
    .magnitude(cur_mag)
);

////////////////////////////////////////////////////////////////////////////
// register writes
// reset values
always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        voltage_reference_control <= `ARCR_RESET_VOLTAGE;
        current_reference_control <= `ARCR_RESET_CURRENT;
    end else if (sfr_wr) begin
        if (sfr_addr == `ARCR_ADDR_VOLTAGE) begin
            voltage_reference_control <= sfr_wdata & `ARCR_VOLTAGE_WMASK;
        end
        if (sfr_addr == `ARCR_ADDR_CURRENT) begin
            current_reference_control <= sfr_wdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// read data, registered; unmapped reads give zero
always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
        case (sfr_addr)
            `ARCR_ADDR_VOLTAGE: sfr_rdata <= voltage_reference_control;
            `ARCR_ADDR_CURRENT: sfr_rdata <= current_reference_control;
            default: sfr_rdata <= 8'h00;
        endcase
    end else begin
        sfr_rdata <= 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////////
// analog control outputs; one cycle behind the stored fields
always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        analog_ground_select <= 1'b0;
        vref_source_select <= `ARCR_SRC_DIG_1V8 | `ARCR_SRC_SUPPLY;
        temp_sensor_enable <= 1'b0;
        precision_ref_output_enable <= 1'b0;
        hs_ref_enable <= 1'b0;
        iref_enable <= 1'b0;
        iref_sink <= 1'b0;
        iref_magnitude_ua <= 9'h000;
    end else begin
        analog_ground_select <= voltage_reference_control[`ARCR_BIT_GND];
        vref_source_select <=
            voltage_reference_control[`ARCR_BIT_SRC_HI:`ARCR_BIT_SRC_LO];
        temp_sensor_enable <= voltage_reference_control[`ARCR_BIT_TEMP];
        precision_ref_output_enable <=
            voltage_reference_control[`ARCR_BIT_PREC];
        // only when selected and converter active
        hs_ref_enable <= busy_sync &&
            (voltage_reference_control[`ARCR_BIT_SRC_HI:`ARCR_BIT_SRC_LO]
             == `ARCR_SRC_HS_1V65);
        // current reference off at zero count
        iref_enable <= cur_en;
        iref_sink <= cur_sink;
        iref_magnitude_ua <= cur_mag;
    end
end
endmodule // arcr_top
`default_nettype wire

// >>> verification/arcr_asserts.sv
`default_nettype none
module arcr_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus and converter
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic converter_busy,
    // analog controls
    input wire logic analog_ground_select,
    input wire logic [1:0] vref_source_select,
    input wire logic temp_sensor_enable,
    input wire logic precision_ref_output_enable,
    input wire logic hs_ref_enable,
    input wire logic iref_enable,
    input wire logic iref_sink,
    input wire logic [8:0] iref_magnitude_ua
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // write decodes; outputs change one edge after the write edge, sampled at the second
    wire logic vw = sfr_wr && sfr_addr == 8'hd1;
    wire logic cw = sfr_wr && sfr_addr == 8'hb9;
    wire logic [8:0] wmag = sfr_wdata[6] ? {sfr_wdata[5:0], 3'h0}
        : {3'h0, sfr_wdata[5:0]};
    vbits_follow_a: assert property (vw |-> ##2
        {analog_ground_select, temp_sensor_enable, precision_ref_output_enable}
        == $past({sfr_wdata[5], sfr_wdata[2], sfr_wdata[0]}, 2))
        else $error("voltage bits wrong");
    src_follow_a: assert property (vw |-> ##2
        vref_source_select == $past(sfr_wdata[4:3], 2)) else $error("src");
    sink_follow_a: assert property (cw |-> ##2
        iref_sink == $past(sfr_wdata[7], 2)) else $error("sink wrong");
    mag_scale_a: assert property (cw |-> ##2
        iref_magnitude_ua == $past(wmag, 2)) else $error("magnitude wrong");
    iref_off_a: assert property (
        iref_enable == (iref_magnitude_ua != 9'h000)) else $error("enable");
    unused_zero_a: assert property (
        sfr_rd && sfr_addr == 8'hd1 |=> sfr_rdata[7:6] == 2'h0
        && !sfr_rdata[1]) else $error("unused bits read");
    idle_read_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("rdata not idle");
    hs_on_a: assert property (
        (converter_busy && vref_source_select == 2'h3) [*7] |-> hs_ref_enable)
        else $error("hs ref not on");
    hs_off_a: assert property (!converter_busy [*7] |-> !hs_ref_enable)
        else $error("hs ref not off");
endmodule // arcr_asserts
bind arcr_top arcr_asserts u_chk (.*);
`default_nettype wire

// >>> verification/analog_reference_control_regs_bench.sv
`default_nettype none
module analog_reference_control_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, converter_busy = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
    logic analog_ground_select, temp_sensor_enable, precision_ref_output_enable;
    logic hs_ref_enable, iref_enable, iref_sink;
    logic [1:0] vref_source_select;
    logic [8:0] iref_magnitude_ua;
    int err_total = 0, total_checks = 0, cyc = 0;
    // write patterns; loops index these, a bare concatenation cannot be
    logic [7:0] vpat [4] = '{8'hff, 8'h28, 8'h15, 8'hc2};
    logic [7:0] cpat [6] = '{8'hff, 8'h7f, 8'h3f, 8'h81, 8'h80, 8'h00};
    wire logic [10:0] vo = {analog_ground_select, vref_source_select,
        temp_sensor_enable, precision_ref_output_enable};
    wire logic [10:0] io = {iref_enable, iref_sink, iref_magnitude_ua};
    arcr_top uut (.*);
    ////////////////////////////////////////
    initial begin
        forever #2 clk = ~clk;
    end
    // hang guard, far above the hundred or so cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_of_test;
        end
    end
    task chk(input logic [10:0] g, input logic [10:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata, e);
    endtask
    task t_reset;
        chk(vo, 11'h00c);
        chk(io, 11'h000);
        rd(8'hd1, 8'h18);
        rd(8'hb9, 8'h00);
        $display("reset test done");
    endtask
    task t_volt;
        for (int i = 0; i < 4; i++) begin
            d = vpat[i];
            wr(8'hd1, d);
            chk(vo, {d[5], d[4:3], d[2], d[0]});
            rd(8'hd1, d & 8'h3d);
        end
        $display("voltage test done");
    endtask
    task t_cur;
        for (int i = 0; i < 6; i++) begin
            d = cpat[i];
            wr(8'hb9, d);
            chk(io, {|d[5:0], d[7], d[6] ? {d[5:0], 3'h0}
                : {3'h0, d[5:0]}});
            rd(8'hb9, d);
        end
        $display("current test done");
    endtask
    task t_map;
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h00);
        rd(8'hb9, 8'h00);
        chk(vo, 11'h000);
        $display("unmapped test done");
    endtask
    task t_hs;
        wr(8'hd1, 8'h18);
        @(posedge clk);
        converter_busy <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(hs_ref_enable, 1'b1);
        // converter idle again: reference must drop by itself
        @(posedge clk);
        converter_busy <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk(hs_ref_enable, 1'b0);
        @(posedge clk);
        converter_busy <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(hs_ref_enable, 1'b1);
        wr(8'hd1, 8'h00);
        repeat (8) @(posedge clk);
        #1;
        chk(hs_ref_enable, 1'b0);
        $display("hs reference test done");
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // reset for eight cycles, then three edges before any request
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_volt;
        t_cur;
        t_map;
        t_hs;
        end_of_test;
    end
endmodule // analog_reference_control_regs_bench
`default_nettype wire
